// [verilog/pmc_pkg.sv]
// Purpose: Shared constants and types for the power mode exit clock control
// Assumes: One 50 MHz clock, 8-bit register port
// Notes: Wake delay and divider counts are derived from times and rates by expressions; edge, timeout and tick counts are literals
package pmc_pkg;

  // ==========================================================
  // Timing
  localparam int CLK_FREQ_HZ = 50_000_000;
  localparam int CLK_PERIOD_NS = 20;
  localparam int WAKE_DELAY_NS = 10_000;
  localparam int WAKE_DLY_CYC = (WAKE_DELAY_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int INT_BLOCK_HZ = 8_000_000;
  localparam int LF_INT_HZ = INT_BLOCK_HZ / 256;
  localparam int LF_DIV = CLK_FREQ_HZ / LF_INT_HZ;
  localparam int START_EDGES = 1024;
  localparam int FAIL_TIMEOUT_CYC = 256;
  localparam int WD_BASE_TICKS = 128;

  // ==========================================================
  // Register map and fields
  localparam logic [3:0] REG_OSC_CTRL = 4'h0;
  localparam logic [3:0] REG_OSC_TRIM = 4'h1;
  localparam logic [3:0] REG_WD_CTRL = 4'h2;
  localparam logic [3:0] REG_IRQ_STAT = 4'h3;
  localparam logic [3:0] REG_IRQ_EN = 4'h4;
  localparam logic [3:0] REG_IRQ_CLR = 4'h5;
  localparam int OCR_IDLE_BIT = 7;
  localparam int OCR_IFS_LSB = 4;
  localparam int OCR_READY_BIT = 3;
  localparam int OCR_INTRUN_BIT = 2;
  localparam int OCR_SEL_LSB = 0;
  localparam int WDC_EN_BIT = 0;
  localparam int WDC_POST_LSB = 1;
  localparam int IRQ_W = 4;
  localparam int IRQ_CLK_READY = 0;
  localparam int IRQ_WD_WAKE = 1;
  localparam int IRQ_CLK_FAIL = 2;
  localparam int IRQ_WD_RESET = 3;
  localparam logic [7:0] OSC_CTRL_RST = 8'h00;
  localparam logic [4:0] OSC_TRIM_RST = 5'h00;
  localparam logic [7:0] WD_CTRL_RST = 8'h00;
  localparam logic [3:0] IRQ_RST = 4'h0;

  // ==========================================================
  // Types
  typedef enum logic [2:0] {
    OM_LOW_POWER_CRYSTAL = 3'h0, OM_STANDARD_CRYSTAL = 3'h1,
    OM_HIGH_SPEED_CRYSTAL = 3'h2, OM_MULTIPLIED_CRYSTAL = 3'h3,
    OM_EXTERNAL_CLOCK = 3'h4, OM_EXTERNAL_CLOCK_IO = 3'h5,
    OM_RESISTOR_CAP = 3'h6, OM_INTERNAL_OSC_IO = 3'h7
  } pmc_oscmode_e;
  typedef enum logic [1:0] {
    CLK_PRI = 2'h0, CLK_LF_INT = 2'h1, CLK_INT_BLOCK = 2'h2
  } pmc_clksrc_e;
  typedef enum logic [4:0] {
    ST_HOLD = 5'h01, ST_RUN = 5'h02, ST_IDLE = 5'h04, ST_SLEEP = 5'h08, ST_WAKE = 5'h10
  } pmc_state_e;

  // Crystal modes need the start-up count
  function automatic logic needsStartup(input logic [2:0] mode);
    needsStartup = (mode <= 3'(OM_MULTIPLIED_CRYSTAL));
  endfunction : needsStartup

  // Trimmed low-frequency divider period, larger trim runs faster
  function automatic logic [11:0] trimDiv(input logic [4:0] trim);
    trimDiv = 12'(LF_DIV) - {{7{trim[4]}}, trim};
  endfunction : trimDiv

endpackage : pmc_pkg

// [verilog/pmc_sync3.sv]
// Purpose: Three-stage pin synchroniser with agreement filter
// Assumes: Inputs asynchronous to mclk
// Notes: Output moves only when stages two and three agree
`timescale 1ns/1ps
module pmc_sync3 #(
  parameter int W = 1,
  parameter logic [W-1:0] INIT = '0
) (
  input wire logic mclk,
  input wire logic rst,
  input wire logic [W-1:0] pinIn,
  output logic [W-1:0] pinOut
);
  logic [W-1:0] s1_r, s2_r, s3_r, out_r, out_nxt, agree;

  // Take stage two where stages two and three agree
  always_comb begin
    agree = s2_r ~^ s3_r;
    out_nxt = (s2_r & agree) | (out_r & ~agree);
  end

  // Shift chain
  always_ff @(posedge mclk) begin
    if (rst) begin
      s1_r <= INIT;
      s2_r <= INIT;
      s3_r <= INIT;
      out_r <= INIT;
    end else begin
      s1_r <= pinIn;
      s2_r <= s1_r;
      s3_r <= s2_r;
      out_r <= out_nxt;
    end
  end

  assign pinOut = out_r;
endmodule : pmc_sync3

// [verilog/pmc_watchdog.sv]
// Purpose: Watchdog counter with postscaler on the low-frequency tick
// Assumes: tick is a one-cycle enable at the low-frequency rate
// Notes: timeout is a one-cycle registered pulse
`timescale 1ns/1ps
module pmc_watchdog
  import pmc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic tick,
  input wire logic enable,
  input wire logic clear,
  input wire logic [3:0] postSel,
  output logic timeout
);
  logic [6:0] tickCnt_r, tickCnt_nxt;
  logic [15:0] post_r, post_nxt, postLimit;
  logic timeout_r, timeout_nxt;

  // Base period then postscaler, both cleared together
  always_comb begin
    tickCnt_nxt = tickCnt_r;
    post_nxt = post_r;
    timeout_nxt = 1'b0;
    postLimit = 16'h0001 << postSel;
    if (clear || !enable) begin
      tickCnt_nxt = 7'h00;
      post_nxt = 16'h0000;
    end else if (tick) begin
      if (tickCnt_r == 7'(WD_BASE_TICKS - 1)) begin
        tickCnt_nxt = 7'h00;
        if (post_r == postLimit - 16'h0001) begin
          post_nxt = 16'h0000;
          timeout_nxt = 1'b1;
        end else begin
          post_nxt = post_r + 16'h0001;
        end
      end else begin
        tickCnt_nxt = tickCnt_r + 7'h01;
      end
    end
  end

  // Counter registers
  always_ff @(posedge mclk) begin
    if (rst) begin
      tickCnt_r <= 7'h00;
      post_r <= 16'h0000;
      timeout_r <= 1'b0;
    end else begin
      tickCnt_r <= tickCnt_nxt;
      post_r <= post_nxt;
      timeout_r <= timeout_nxt;
    end
  end

  assign timeout = timeout_r;

  default clocking cbw @(posedge mclk); endclocking
  default disable iff (rst);
  AST_WD_CLEARED: assert property (clear |=> tickCnt_r == 7'h00 && post_r == 16'h0000
    && !timeout_r) else $error("watchdog not cleared");
endmodule : pmc_watchdog

// [verilog/pmc_clock_ctrl.sv]
// Purpose: Clock control on reset and power-managed mode exit
// Assumes: Config straps steady around reset, CPU strobes on mclk
// Notes:
// Notes on behaviour
// - Hold in reset until primary clock ready, then set ready flag and run.
// - Dual-speed or fail monitor config lets execution start early on internal clock.
// - Every reset clears oscillator control, selecting the low-frequency internal clock.
// - Writing the frequency select moves execution to that internal block output; here only while the clock select is nonzero or the primary is not ready.
// - Internal clock until primary ready; sleeping before then shuts the primary.
// - Watchdog timeout in idle or sleep wakes the device instead of resetting.
// - Watchdog timeout while running produces a watchdog reset.
// - Halt, clear instruction, clock loss, select change while internal clear watchdog.
// - Primary idle exits and non-crystal modes skip the start-up count.
// - Wake inserts a fixed 10 us delay; execution resumes after it once primary ready, early run set or internal clock selected.
// - Internal block nominally 8 MHz, trimmable through the trim register.
// - Trim also shifts the low-frequency clock feeding the watchdog; the fail monitor counts mclk cycles.
// - Resistor-capacitor mode drives quarter of first pin rate on second pin.
// - Port A bits 6 and 7 usable only in freeing modes, else read zero.
//
// The implementer's own choices: the address-and-strobe port and the address map.
`timescale 1ns/1ps
module pmc_clock_ctrl
  import pmc_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic [3:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdData,
  input wire logic cfgTwoSpeed,
  input wire logic cfgFailSafe,
  input wire logic [2:0] cfgOscMode,
  input wire logic masterClearN,
  input wire logic firstOscPin,
  input wire logic [1:0] portAHiPin,
  input wire logic haltInstr,
  input wire logic watchdogClearInstr,
  input wire logic wakeEvent,
  output logic cpuRun,
  output logic cpuReset,
  output logic watchdogReset,
  output logic primOscEn,
  output logic [1:0] sysClkSrc,
  output logic [2:0] intFreqSel,
  output logic [4:0] oscTrim,
  output logic secondOscOut,
  output logic secondOscOeN,
  output logic portA6En,
  output logic portA7En,
  output logic [1:0] portAHiRd,
  output logic irq
);
  // ==========================================================
  // Pin synchronisers and straps
  logic [3:0] pinSync;
  logic masterClearSync, oscSync, oscPrev_r, oscRise;
  logic cfgTwoSpeed_r, cfgFailSafe_r, cfgTwoSpeed_nxt, cfgFailSafe_nxt;
  logic [2:0] cfgMode_r, cfgMode_nxt;
  logic earlyRun;

  pmc_sync3 #(.W(4), .INIT(4'h1)) uSync (
    .mclk(mclk),
    .rst(rst),
    .pinIn({portAHiPin, firstOscPin, masterClearN}),
    .pinOut(pinSync)
  );

  assign masterClearSync = pinSync[0];
  assign oscSync = pinSync[1];
  assign oscRise = oscSync && !oscPrev_r;
  assign earlyRun = cfgTwoSpeed_r || cfgFailSafe_r;

  // Straps follow the inputs while reset is held
  always_comb begin
    cfgTwoSpeed_nxt = rst ? cfgTwoSpeed : cfgTwoSpeed_r;
    cfgFailSafe_nxt = rst ? cfgFailSafe : cfgFailSafe_r;
    cfgMode_nxt = rst ? cfgOscMode : cfgMode_r;
  end

  // Strap and edge registers
  always_ff @(posedge mclk) begin
    cfgTwoSpeed_r <= cfgTwoSpeed_nxt;
    cfgFailSafe_r <= cfgFailSafe_nxt;
    cfgMode_r <= cfgMode_nxt;
    oscPrev_r <= rst ? 1'b0 : oscSync;
  end

  // ==========================================================
  // Shared event terms
  pmc_state_e state_r, state_nxt;
  logic idleEn_r, idleEn_nxt, primReady_r, primReady_nxt, primEn_r, primEn_nxt;
  logic [2:0] intFreq_r, intFreq_nxt;
  logic [1:0] clkSel_r, clkSel_nxt, sysClk_r, sysClk_nxt;
  logic wdTimeout, wdClear, wdResetEvt, wdWakeEvt, clkFailEvt, freqChange, softReset;
  logic wrOsc, wrTrim, wrWd, wrEn, wrClr, inPowerMode;
  logic [3:0] irqEvents;

  assign wrOsc = regWr && regAddr == REG_OSC_CTRL;
  assign wrTrim = regWr && regAddr == REG_OSC_TRIM;
  assign wrWd = regWr && regAddr == REG_WD_CTRL;
  assign wrEn = regWr && regAddr == REG_IRQ_EN;
  assign wrClr = regWr && regAddr == REG_IRQ_CLR;
  assign inPowerMode = state_r == ST_IDLE || state_r == ST_SLEEP;
  assign wdResetEvt = wdTimeout && state_r == ST_RUN;
  assign wdWakeEvt = wdTimeout && inPowerMode;
  assign softReset = !masterClearSync || wdResetEvt;
  assign freqChange = wrOsc && regWrData[OCR_IFS_LSB +: 3] != intFreq_r
    && sysClk_r != CLK_PRI;
  assign wdClear = (state_r == ST_RUN && haltInstr) || watchdogClearInstr
    || clkFailEvt || freqChange;
  assign irqEvents = {wdResetEvt, clkFailEvt, wdWakeEvt, primReady_nxt && !primReady_r};

  // ==========================================================
  // Register file
  logic [4:0] trim_r, trim_nxt;
  logic wdEn_r, wdEn_nxt;
  logic [3:0] wdPost_r, wdPost_nxt, irqEn_r, irqEn_nxt, irqStat_r, irqStat_nxt;
  logic [7:0] rdData_r, rdData_nxt;
  logic irq_r, irq_nxt;

  // Writes, sticky status with set over clear, read port
  always_comb begin
    idleEn_nxt = idleEn_r;
    intFreq_nxt = intFreq_r;
    clkSel_nxt = clkSel_r;
    trim_nxt = trim_r;
    wdEn_nxt = wdEn_r;
    wdPost_nxt = wdPost_r;
    irqEn_nxt = irqEn_r;
    if (softReset) begin
      {idleEn_nxt, intFreq_nxt, clkSel_nxt} = {OSC_CTRL_RST[7:4], OSC_CTRL_RST[1:0]};
      trim_nxt = OSC_TRIM_RST;
      {wdPost_nxt, wdEn_nxt} = WD_CTRL_RST[4:0];
    end else begin
      if (wrOsc) begin
        idleEn_nxt = regWrData[OCR_IDLE_BIT];
        intFreq_nxt = regWrData[OCR_IFS_LSB +: 3];
        clkSel_nxt = regWrData[OCR_SEL_LSB +: 2];
      end
      if (wrTrim) trim_nxt = regWrData[4:0];
      if (wrWd) begin
        wdEn_nxt = regWrData[WDC_EN_BIT];
        wdPost_nxt = regWrData[WDC_POST_LSB +: 4];
      end
    end
    if (wrEn) irqEn_nxt = regWrData[IRQ_W-1:0];
    irqStat_nxt = (irqStat_r & ~(wrClr ? regWrData[IRQ_W-1:0] : 4'h0)) | irqEvents;
    irq_nxt = |(irqStat_nxt & irqEn_nxt);
    rdData_nxt = 8'h00;
    if (regRd) begin
      case (regAddr)
        REG_OSC_CTRL: rdData_nxt = {idleEn_r, intFreq_r, primReady_r,
          sysClk_r != CLK_PRI, clkSel_r};
        REG_OSC_TRIM: rdData_nxt = {3'h0, trim_r};
        REG_WD_CTRL: rdData_nxt = {3'h0, wdPost_r, wdEn_r};
        REG_IRQ_STAT: rdData_nxt = {4'h0, irqStat_r};
        REG_IRQ_EN: rdData_nxt = {4'h0, irqEn_r};
        default: rdData_nxt = 8'h00;
      endcase
    end
  end

  // Register file flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      {idleEn_r, intFreq_r, clkSel_r} <= {OSC_CTRL_RST[7:4], OSC_CTRL_RST[1:0]};
      trim_r <= OSC_TRIM_RST;
      {wdPost_r, wdEn_r} <= WD_CTRL_RST[4:0];
      irqEn_r <= IRQ_RST;
      irqStat_r <= IRQ_RST;
      rdData_r <= 8'h00;
      irq_r <= 1'b0;
    end else begin
      idleEn_r <= idleEn_nxt;
      intFreq_r <= intFreq_nxt;
      clkSel_r <= clkSel_nxt;
      trim_r <= trim_nxt;
      wdEn_r <= wdEn_nxt;
      wdPost_r <= wdPost_nxt;
      irqEn_r <= irqEn_nxt;
      irqStat_r <= irqStat_nxt;
      rdData_r <= rdData_nxt;
      irq_r <= irq_nxt;
    end
  end

  // ==========================================================
  // Clock sources, start-up count, fail monitor, pins
  logic [10:0] startCnt_r, startCnt_nxt;
  logic [8:0] failCnt_r, failCnt_nxt;
  logic [11:0] lfDiv_r, lfDiv_nxt;
  logic lfTick_r, lfTick_nxt;
  logic [1:0] quarter_r, quarter_nxt, portHi_r, portHi_nxt;
  logic secOut_r, secOut_nxt, secOeN_r, secOeN_nxt, a6En_r, a6En_nxt, a7En_r, a7En_nxt;
  logic rcMode;

  assign rcMode = cfgMode_r == 3'(OM_RESISTOR_CAP);
  assign clkFailEvt = cfgFailSafe_r && primReady_r && sysClk_r == CLK_PRI
    && failCnt_r == 9'(FAIL_TIMEOUT_CYC - 1);

  // Next values of the clock group
  always_comb begin
    startCnt_nxt = startCnt_r;
    primReady_nxt = primReady_r;
    if (!primEn_r || clkFailEvt) begin
      startCnt_nxt = 11'h000;
      primReady_nxt = 1'b0;
    end else if (!needsStartup(cfgMode_r)) begin
      primReady_nxt = 1'b1;
    end else if (!primReady_r && oscRise) begin
      startCnt_nxt = startCnt_r + 11'h001;
      primReady_nxt = startCnt_r == 11'(START_EDGES - 1);
    end
    failCnt_nxt = (oscRise || !primReady_r) ? 9'h000 : failCnt_r + 9'h001;
    if (clkFailEvt) failCnt_nxt = 9'h000;
    lfTick_nxt = lfDiv_r == 12'h000;
    lfDiv_nxt = lfTick_nxt ? trimDiv(trim_r) - 12'h001 : lfDiv_r - 12'h001;
    if (clkSel_r == 2'h0 && primReady_nxt) begin
      sysClk_nxt = CLK_PRI;
    end else begin
      sysClk_nxt = (intFreq_nxt == 3'h0) ? CLK_LF_INT : CLK_INT_BLOCK;
    end
    quarter_nxt = (rcMode && oscRise) ? quarter_r + 2'h1 : quarter_r;
    secOut_nxt = rcMode && quarter_nxt[1];
    secOeN_nxt = !rcMode;
    a6En_nxt = cfgMode_r == 3'(OM_EXTERNAL_CLOCK_IO) || cfgMode_r == 3'(OM_INTERNAL_OSC_IO);
    a7En_nxt = cfgMode_r == 3'(OM_INTERNAL_OSC_IO);
    portHi_nxt = pinSync[3:2] & {a7En_nxt, a6En_nxt};
  end

  // Clock group flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      startCnt_r <= 11'h000;
      primReady_r <= 1'b0;
      failCnt_r <= 9'h000;
      lfDiv_r <= 12'h000;
      lfTick_r <= 1'b0;
      sysClk_r <= CLK_LF_INT;
      quarter_r <= 2'h0;
      secOut_r <= 1'b0;
      secOeN_r <= 1'b1;
      a6En_r <= 1'b0;
      a7En_r <= 1'b0;
      portHi_r <= 2'h0;
    end else begin
      startCnt_r <= startCnt_nxt;
      primReady_r <= primReady_nxt;
      failCnt_r <= failCnt_nxt;
      lfDiv_r <= lfDiv_nxt;
      lfTick_r <= lfTick_nxt;
      sysClk_r <= sysClk_nxt;
      quarter_r <= quarter_nxt;
      secOut_r <= secOut_nxt;
      secOeN_r <= secOeN_nxt;
      a6En_r <= a6En_nxt;
      a7En_r <= a7En_nxt;
      portHi_r <= portHi_nxt;
    end
  end

  pmc_watchdog uWatchdog (
    .mclk(mclk),
    .rst(rst),
    .tick(lfTick_r),
    .enable(wdEn_r),
    .clear(wdClear),
    .postSel(wdPost_r),
    .timeout(wdTimeout)
  );

  // ==========================================================
  // Power mode sequencer
  logic [8:0] wakeCnt_r, wakeCnt_nxt;
  logic cpuRun_r, cpuReset_r, wdReset_r, wakeDone;

  assign wakeDone = wakeCnt_r == 9'(WAKE_DLY_CYC - 1);

  // Next state and primary enable
  always_comb begin
    state_nxt = state_r;
    primEn_nxt = primEn_r;
    wakeCnt_nxt = 9'h000;
    unique case (state_r)
      ST_HOLD: begin
        primEn_nxt = 1'b1;
        if (masterClearSync && (primReady_r || earlyRun)) state_nxt = ST_RUN;
      end
      ST_RUN: begin
        if (haltInstr) begin
          state_nxt = idleEn_r ? ST_IDLE : ST_SLEEP;
          primEn_nxt = idleEn_r && primReady_r;
        end
      end
      ST_IDLE, ST_SLEEP: begin
        if (wakeEvent || wdWakeEvt) begin
          state_nxt = ST_WAKE;
          primEn_nxt = 1'b1;
        end
      end
      ST_WAKE: begin
        wakeCnt_nxt = wakeDone ? wakeCnt_r : wakeCnt_r + 9'h001;
        if (wakeDone && (primReady_r || earlyRun || clkSel_r != 2'h0)) begin
          state_nxt = ST_RUN;
        end
      end
      default: state_nxt = ST_HOLD;
    endcase
    if (softReset) begin
      state_nxt = ST_HOLD;
      primEn_nxt = 1'b1;
    end
  end

  // Sequencer flops
  always_ff @(posedge mclk) begin
    if (rst) begin
      state_r <= ST_HOLD;
      primEn_r <= 1'b1;
      wakeCnt_r <= 9'h000;
      cpuRun_r <= 1'b0;
      cpuReset_r <= 1'b1;
      wdReset_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      primEn_r <= primEn_nxt;
      wakeCnt_r <= wakeCnt_nxt;
      cpuRun_r <= state_nxt == ST_RUN;
      cpuReset_r <= state_nxt == ST_HOLD;
      wdReset_r <= wdResetEvt;
    end
  end

  // Outputs straight from flops
  assign regRdData = rdData_r;
  assign cpuRun = cpuRun_r;
  assign cpuReset = cpuReset_r;
  assign watchdogReset = wdReset_r;
  assign primOscEn = primEn_r;
  assign sysClkSrc = sysClk_r;
  assign intFreqSel = intFreq_r;
  assign oscTrim = trim_r;
  assign secondOscOut = secOut_r;
  assign secondOscOeN = secOeN_r;
  assign portA6En = a6En_r;
  assign portA7En = a7En_r;
  assign portAHiRd = portHi_r;
  assign irq = irq_r;

  // ==========================================================
  // Checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);
  AST_HOLD_UNTIL_READY: assert property ($rose(cpuRun_r) && $past(state_r) == ST_HOLD
    |-> $past(primReady_r || earlyRun)) else $error("left reset hold too early");
  AST_READY_FLAG: assert property (regRd && regAddr == REG_OSC_CTRL && !primReady_r
    |=> !regRdData[OCR_READY_BIT]) else $error("ready flag high without primary");
  AST_RESET_CLEARS: assert property ($past(!masterClearSync) |-> clkSel_r == 2'h0
    && intFreq_r == 3'h0 && !idleEn_r) else $error("control not cleared by reset");
  AST_FREQ_SELECT: assert property (clkSel_r != 2'h0 && intFreq_r != 3'h0 && !wrOsc
    && !softReset |=> sysClk_r == CLK_INT_BLOCK) else $error("internal block not selected");
  AST_PRIMARY_OFF: assert property (state_r == ST_RUN && haltInstr && !primReady_r
    && !softReset |=> !primEn_r ##1 !primReady_r) else $error("primary not shut down");
  AST_WD_WAKE: assert property (wdWakeEvt && masterClearSync |=> state_r == ST_WAKE
    && !wdReset_r && !cpuReset_r) else $error("watchdog in power mode did not wake");
  AST_WD_RESET: assert property (wdResetEvt |=> wdReset_r && cpuReset_r
    && clkSel_r == 2'h0) else $error("watchdog in run did not reset");
  AST_SKIP_START: assert property (primEn_r && !needsStartup(cfgMode_r)
    && !clkFailEvt |=> primReady_r) else $error("start-up count not skipped");
  AST_WAKE_DELAY: assert property (state_r == ST_RUN && $past(state_r) == ST_WAKE
    |-> $past(wakeCnt_r) == 9'(WAKE_DLY_CYC - 1) && cpuRun_r) else $error("wake delay wrong");
  AST_QUARTER_OUT: assert property (rcMode && oscRise && quarter_r[0]
    |=> secondOscOut != $past(secondOscOut) && !secondOscOeN) else $error("quarter clock wrong");
  AST_PORT_HI_ZERO: assert property (cfgMode_r != 3'(OM_INTERNAL_OSC_IO)
    |=> !portHi_r[1] && !a7En_r) else $error("disabled port bit read nonzero");
  COV_WD_WAKE: cover property (wdWakeEvt ##1 state_r == ST_WAKE);
  COV_WD_RESET: cover property (wdResetEvt ##1 cpuReset_r);
  COV_EARLY_RUN: cover property (cpuRun_r && !primReady_r && sysClk_r != CLK_PRI);
  COV_CLK_FAIL: cover property (clkFailEvt);
endmodule : pmc_clock_ctrl

// [sim/pmc_osc_model.sv]
// Purpose: Far-side model of the oscillator source and master clear pin
// Assumes: Oscillator runs only while the device enables it
// Notes: Pin half period is counted in mclk cycles
`timescale 1ns/1ps
module pmc_osc_model #(
  parameter int HALF = 4
) (
  input wire logic mclk,
  input wire logic oscEn,
  input wire logic pullClear,
  output logic oscPin,
  output logic masterClearN
);
  int cnt = 0;
  // ==========================================================
  // Oscillator, stands still low while disabled
  initial oscPin = 1'b0;
  always @(posedge mclk) begin
    if (!oscEn) begin
      oscPin <= 1'b0;
      cnt <= 0;
    end else if (cnt == HALF - 1) begin
      oscPin <= ~oscPin;
      cnt <= 0;
    end else begin
      cnt <= cnt + 1;
    end
  end
  // Reset pin pulled low on request
  assign masterClearN = ~pullClear;
endmodule : pmc_osc_model

// [sim/tb_top.sv]
// Purpose: Self-checking bench for the clock control block
// Assumes: Partner model supplies oscillator and master clear pins
// Notes: Watchdog timeouts outlast the run, left to the assertions
`timescale 1ns/1ps
module tb_top
  import pmc_pkg::*;
;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic [3:0] regAddr = 4'h0;
  logic [7:0] regWrData = 8'h00;
  logic regWr = 1'b0;
  logic regRd = 1'b0;
  logic cfgTwoSpeed = 1'b0;
  logic cfgFailSafe = 1'b0;
  logic [2:0] cfgOscMode = 3'h1;
  logic haltInstr = 1'b0;
  logic wakeEvent = 1'b0;
  logic pullClear = 1'b0;
  logic [7:0] regRdData, rd;
  logic masterClearN, firstOscPin, cpuRun, cpuReset, primOscEn, secondOscOut, secondOscOeN;
  logic portA6En, portA7En, irq, watchdogReset;
  logic [1:0] sysClkSrc, portAHiRd;
  logic [2:0] intFreqSel;
  logic [4:0] oscTrim;
  int nMismatch = 0;
  int checksDone = 0;
  int n;
  // Clock
  always #10 mclk = ~mclk;
  pmc_osc_model #(.HALF(4)) osc (.mclk(mclk), .oscEn(primOscEn), .pullClear(pullClear),
    .oscPin(firstOscPin), .masterClearN(masterClearN));
  pmc_clock_ctrl dut (.mclk(mclk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWr(regWr), .regRd(regRd), .regRdData(regRdData), .cfgTwoSpeed(cfgTwoSpeed),
    .cfgFailSafe(cfgFailSafe), .cfgOscMode(cfgOscMode), .masterClearN(masterClearN),
    .firstOscPin(firstOscPin), .portAHiPin(2'h3), .haltInstr(haltInstr),
    .watchdogClearInstr(1'b0), .wakeEvent(wakeEvent), .cpuRun(cpuRun), .cpuReset(cpuReset),
    .watchdogReset(watchdogReset), .primOscEn(primOscEn), .sysClkSrc(sysClkSrc),
    .intFreqSel(intFreqSel),
    .oscTrim(oscTrim), .secondOscOut(secondOscOut), .secondOscOeN(secondOscOeN),
    .portA6En(portA6En), .portA7En(portA7En), .portAHiRd(portAHiRd), .irq(irq));
  // ==========================================================
  // Tasks
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    checksDone++;
    if (got !== exp) begin
      nMismatch++;
      $display("wrong value %s expected %0h seen %0h", nm, exp, got);
    end
  endtask : chk
  task automatic wrReg(input logic [3:0] a, input logic [7:0] d);
    regAddr <= a;
    regWrData <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
    @(posedge mclk);
  endtask : wrReg
  task automatic rdReg(input logic [3:0] a);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    #1 rd = regRdData;
    @(posedge mclk);
  endtask : rdReg
  task automatic doReset(input logic [2:0] m, input logic two, input logic fs);
    rst <= 1'b1;
    cfgOscMode <= m;
    cfgTwoSpeed <= two;
    cfgFailSafe <= fs;
    repeat (20) @(posedge mclk);
    rst <= 1'b0;
  endtask : doReset
  task automatic waitRun(input int lim);
    n = 0;
    while (cpuRun !== 1'b1 && n < lim) begin
      @(negedge mclk);
      n++;
    end
    @(posedge mclk);
  endtask : waitRun
  task automatic waitRise();
    logic p;
    n = 0;
    p = 1'b1;
    while (!(p === 1'b0 && secondOscOut === 1'b1) && n < 200) begin
      p = secondOscOut;
      @(negedge mclk);
      n++;
    end
  endtask : waitRise
  task automatic halt();
    haltInstr <= 1'b1;
    @(posedge mclk);
    haltInstr <= 1'b0;
    #1 chk("cpuRun", 0, cpuRun);
    @(posedge mclk);
  endtask : halt
  task automatic giveVerdict();
    if (nMismatch == 0 && checksDone > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : giveVerdict
  // ==========================================================
  // Watchdog against a hang
  initial begin
    repeat (40000) @(posedge mclk);
    nMismatch++;
    giveVerdict();
  end
  // Main sequence
  initial begin
    doReset(OM_STANDARD_CRYSTAL, 1'b0, 1'b0);
    @(negedge mclk);
    chk("cpuReset", 1, cpuReset);
    chk("sysClkSrc", CLK_LF_INT, sysClkSrc);
    chk("portAHiRd", 0, portAHiRd);
    @(posedge mclk);
    rdReg(REG_OSC_CTRL);
    chk("readyHold", 0, rd[OCR_READY_BIT]);
    waitRun(20000);
    chk("cpuRun", 1, cpuRun);
    rdReg(REG_OSC_CTRL);
    chk("ctrlReady", 8'h08, rd);
    // Interrupt raised, masked, enabled, cleared
    rdReg(REG_IRQ_STAT);
    chk("irqStat", 8'h01, rd);
    chk("irqMasked", 0, irq);
    wrReg(REG_IRQ_EN, 8'h01);
    repeat (2) @(posedge mclk);
    chk("irqOn", 1, irq);
    wrReg(REG_IRQ_CLR, 8'h01);
    wrReg(REG_IRQ_STAT, 8'hFF);
    rdReg(REG_IRQ_STAT);
    chk("irqStatClr", 0, rd);
    chk("irqOff", 0, irq);
    rdReg(4'hA);
    chk("unmapped", 0, rd);
    // Faster internal output and trim
    wrReg(REG_OSC_CTRL, 8'h52);
    wrReg(REG_OSC_TRIM, 8'h0F);
    rdReg(REG_OSC_CTRL);
    chk("ctrlRw", 8'h52, rd & 8'hF3);
    chk("intFreqSel", 5, intFreqSel);
    chk("sysClkSrc", CLK_INT_BLOCK, sysClkSrc);
    chk("oscTrim", 5'h0F, oscTrim);
    // Sleep then wake after the fixed delay
    halt();
    wakeEvent <= 1'b1;
    @(posedge mclk);
    wakeEvent <= 1'b0;
    waitRun(2000);
    chk("wakeDelay", WAKE_DLY_CYC + 1, n);
    // Master clear pin resets control
    pullClear <= 1'b1;
    repeat (10) @(posedge mclk);
    pullClear <= 1'b0;
    #1 chk("mclrHold", 1, cpuReset);
    chk("mclrNoWd", 0, watchdogReset);
    waitRun(20000);
    rdReg(REG_OSC_CTRL);
    chk("ctrlCleared", 0, rd & 8'hF3);
    chk("trimCleared", 0, oscTrim);
    // Early run on internal clock, sleep before primary ready
    doReset(OM_STANDARD_CRYSTAL, 1'b1, 1'b0);
    waitRun(40);
    chk("earlyRun", 1, cpuRun);
    chk("earlySrc", CLK_LF_INT, sysClkSrc);
    rdReg(REG_OSC_CTRL);
    chk("readyEarly", 0, rd[OCR_READY_BIT]);
    halt();
    chk("primOff", 0, primOscEn);
    // Fail monitor strap alone also allows early run
    doReset(OM_STANDARD_CRYSTAL, 1'b0, 1'b1);
    waitRun(40);
    chk("failSafeRun", 1, cpuRun);
    // Non-crystal modes 5 to 7: no start-up count, pin functions
    for (int m = 5; m < 8; m++) begin
      doReset(3'(m), 1'b0, 1'b0);
      waitRun(40);
      repeat (3) @(negedge mclk);
      chk("noStartup", 1, cpuRun);
      chk("portAEn", {m == 7, m == 5 || m == 7}, {portA7En, portA6En});
      chk("portAHiRd", {m == 7, m == 5 || m == 7}, portAHiRd);
      chk("secondOe", m != 6, secondOscOeN);
      if (m == 6) begin
        waitRise();
        waitRise();
        chk("quarterPeriod", 32, n);
      end
      @(posedge mclk);
    end
    giveVerdict();
  end
endmodule : tb_top
